/* File: hdl/dac_device.sv */
/*
 * Device end: serial input shift register on the link clock, frame check,
 * per-channel data, pending and output registers, switch decode and range
 * scaling on the core clock. Assumes the host stops the link clock outside
 * frames and keeps frame select high for several core cycles between them.
 */
`timescale 1ns/100ps
module dac_device (
    input  wire logic                                            clk,
    input  wire logic                                            arst_n,
    dac_link_if.dev                                              link,
    output logic [dac_pkg::NCH-1:0][dac_pkg::CUR_W-1:0]          channelCurrentOutput,
    output logic [dac_pkg::NCH-1:0]                              chanTristate,
    output logic [dac_pkg::NCH-1:0][dac_pkg::SEG_W-1:0]          segmentSwitches,
    output logic [dac_pkg::NCH-1:0][dac_pkg::LAD_W-1:0]          ladderSwitches,
    output logic                                                 frameErr
);
    import dac_pkg::*;

    function automatic logic [SEG_W-1:0] therm(input logic [3:0] v);
        logic [SEG_W-1:0] t;
        t = '0;
        for (int i = 0; i < SEG_W; i++) begin
            t[i] = (32'(v) > i);
        end
        return t;
    endfunction

    function automatic logic [CUR_W-1:0] curOf(input logic [1:0] r,
                                              input logic [CODE_W-1:0] d);
        logic [CUR_W-1:0] s;
        logic [CUR_W-1:0] o;
        s = SPAN_20;
        o = '0;
        if (r == RANGE_0_24) begin
            s = SPAN_24;
        end else if (r == RANGE_4_20) begin
            s = SPAN_16;
            o = OFFSET_4MA;
        end
        return CUR_W'(s * CUR_W'(d)) + o;
    endfunction

    // Link clock domain.
    logic [PEC_BITS-1:0] shift_q;
    logic [CNT_W-1:0]    bitCnt_q;
    logic                fresh_q;
    logic                frameIdle;

    assign frameIdle = link.frameSelN | ~arst_n;

    // Marks the first clock edge of a frame so the bit count restarts there
    // rather than at frame end, where the core domain still has to read it.
    always_ff @(negedge link.sclk or posedge frameIdle) begin
        if (frameIdle) begin
            fresh_q <= 1'h1;
        end else begin
            fresh_q <= 1'h0;
        end
    end

    always_ff @(negedge link.sclk or negedge arst_n) begin
        if (!arst_n) begin
            shift_q <= '0;
        end else if (!link.frameSelN) begin
            shift_q <= {shift_q[PEC_BITS-2:0], link.sdi};
        end
    end

    always_ff @(negedge link.sclk or negedge arst_n) begin
        if (!arst_n) begin
            bitCnt_q <= '0;
        end else if (!link.frameSelN) begin
            if (fresh_q) begin
                bitCnt_q <= CNT_W'(1);
            end else if (bitCnt_q != CNT_MAX) begin
                bitCnt_q <= bitCnt_q + CNT_W'(1);
            end
        end
    end

    // Core domain: pins pass three flops; a value is taken once the second
    // and third agree.
    logic [2:0] pinIn;
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic [2:0] filt_q;

    assign pinIn = {link.packetCheck, link.loadOutputsN, link.frameSelN};

    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                s1_q[i]   <= PIN_RST[i];
                s2_q[i]   <= PIN_RST[i];
                s3_q[i]   <= PIN_RST[i];
                filt_q[i] <= PIN_RST[i];
            end else begin
                s1_q[i] <= pinIn[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    filt_q[i] <= s3_q[i];
                end
            end
        end
    end

    logic                 frameEnd;
    logic                 ldFall;
    logic                 ldRise;
    logic                 ldHigh;
    logic                 packet_check;
    logic                 lenOk;
    logic                 crcOk;
    logic                 frameGood;
    logic [WORD_BITS-1:0] word;
    logic [1:0]           cmd;
    logic [CODE_W-1:0]    wdata;

    assign frameEnd = (s2_q[PIN_FS] == s3_q[PIN_FS]) & s3_q[PIN_FS] & ~filt_q[PIN_FS];
    assign ldRise = (s2_q[PIN_LD] == s3_q[PIN_LD]) & s3_q[PIN_LD] & ~filt_q[PIN_LD];
    assign ldFall = (s2_q[PIN_LD] == s3_q[PIN_LD]) & ~s3_q[PIN_LD] & filt_q[PIN_LD];
    assign ldHigh = filt_q[PIN_LD];
    assign packet_check = filt_q[PIN_PEC];

    // The shift register is stable here: the link clock has stopped before
    // frame select rose and the synchroniser adds further settling time.
    assign word = packet_check ? shift_q[PEC_BITS-1:CRC_W] : shift_q[WORD_BITS-1:0];
    assign lenOk = bitCnt_q == (packet_check ? LEN_PEC : LEN_PLAIN);
    assign crcOk = !packet_check || (crc8(word) == shift_q[CRC_W-1:0]);
    assign frameGood = frameEnd & lenOk & crcOk;
    assign cmd = word[CMD_HI:CMD_LO];
    assign wdata = word[CODE_W-1:0];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frameErr <= 1'h0;
        end else begin
            frameErr <= frameEnd & ~(lenOk & crcOk);
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic              hit;
        logic              wrData;
        logic              upd;
        logic [CODE_W-1:0] data_q;
        logic [CODE_W-1:0] pend_q;
        logic              pendV_q;
        logic [CODE_W-1:0] code_q;
        logic [CODE_W-1:0] codeNext;
        logic [1:0]        range_q;
        logic [1:0]        rangeNext;

        assign hit = frameGood && (word[CH_HI:CH_LO] == 2'(c));
        assign wrData = hit && (cmd == CMD_DATA);

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                data_q <= '0;
            end else if (wrData) begin
                data_q <= wdata;
            end
        end

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                pend_q  <= '0;
                pendV_q <= 1'h0;
            end else if (ldRise) begin
                pendV_q <= 1'h0;
            end else if (wrData && ldHigh && !pendV_q) begin
                pend_q  <= wdata;
                pendV_q <= 1'h1;
            end else if (ldFall) begin
                pendV_q <= 1'h0;
            end
        end

        always_comb begin
            codeNext = code_q;
            upd = 1'h0;
            if (wrData && !ldHigh) begin
                codeNext = wdata;
                upd = 1'h1;
            end else if (ldFall && pendV_q) begin
                codeNext = pend_q;
                upd = 1'h1;
            end
        end

        always_comb begin
            rangeNext = range_q;
            if (hit && cmd == CMD_RANGE && wdata[1:0] != RANGE_BAD) begin
                rangeNext = wdata[1:0];
            end
        end

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                code_q  <= '0;
                range_q <= RANGE_0_20;
            end else begin
                code_q  <= codeNext;
                range_q <= rangeNext;
            end
        end

        // Switch and current outputs are registered from the next code so
        // they change on the same edge as the output register itself.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                segmentSwitches[c]      <= '0;
                ladderSwitches[c]       <= '0;
                channelCurrentOutput[c] <= '0;
            end else begin
                segmentSwitches[c]      <= therm(codeNext[CODE_W-1:LAD_W]);
                ladderSwitches[c]       <= codeNext[LAD_W-1:0];
                channelCurrentOutput[c] <= curOf(rangeNext, codeNext);
            end
        end

        // A channel leaves tristate at its first output update.
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                chanTristate[c] <= 1'h1;
            end else if (upd) begin
                chanTristate[c] <= 1'h0;
            end
        end
    end
endmodule

/* File: hdl/dac_pkg.sv */
/*
 * Shared constants, frame layout and the crc8 helper function for the quad current
 * DAC serial link. Assumes both link ends and the bench compile it first.
 */
package dac_pkg;
    localparam int NCH = 4;
    localparam int CODE_W = 16;
    localparam int CUR_W = 21;
    localparam int SEG_W = 15;
    localparam int LAD_W = 12;
    localparam int WORD_BITS = 24;
    localparam int PEC_BITS = 32;
    localparam int CRC_W = 8;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] LEN_PLAIN = 6'h18;
    localparam logic [CNT_W-1:0] LEN_PEC = 6'h20;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
    // Frame word: [23:22] command, [21:20] channel, [15:0] data.
    localparam int CMD_HI = 23;
    localparam int CMD_LO = 22;
    localparam int CH_HI = 21;
    localparam int CH_LO = 20;
    localparam logic [1:0] CMD_DATA = 2'h0;
    localparam logic [1:0] CMD_RANGE = 2'h1;
    localparam logic [1:0] RANGE_0_20 = 2'h0;
    localparam logic [1:0] RANGE_4_20 = 2'h1;
    localparam logic [1:0] RANGE_0_24 = 2'h2;
    localparam logic [1:0] RANGE_BAD = 2'h3;
    // Current is expressed in units of 1/65536 mA.
    localparam logic [CUR_W-1:0] SPAN_20 = 21'h00014;
    localparam logic [CUR_W-1:0] SPAN_24 = 21'h00018;
    localparam logic [CUR_W-1:0] SPAN_16 = 21'h00010;
    localparam logic [CUR_W-1:0] OFFSET_4MA = 21'h40000;
    localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
    localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;
    // Pin synchroniser slots and their idle values.
    localparam int PIN_FS = 0;
    localparam int PIN_LD = 1;
    localparam int PIN_PEC = 2;
    localparam logic [2:0] PIN_RST = 3'h3;
    localparam int CLK_MHZ = 25;
    localparam int CAL_US = 100;
    localparam int CAL_CYCLES = CAL_US * CLK_MHZ;
    localparam int GAP_CYCLES = 8;
    localparam int LD_PULSE_CYCLES = 8;
    localparam int HCNT_W = 12;

    function automatic logic [CRC_W-1:0] crc8(input logic [WORD_BITS-1:0] d);
        logic [CRC_W-1:0] c;
        c = CRC_INIT;
        for (int i = WORD_BITS - 1; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'h0} ^ CRC_POLY) : {c[6:0], 1'h0};
        end
        return c;
    endfunction
endpackage

/* File: hdl/dac_link_if.sv */
/*
 * Serial link between the host controller and the DAC device.
 * Assumes the host or the bench drives every wire; the bench instantiates it twice.
 */
`timescale 1ns/100ps
interface dac_link_if;
    logic sclk;
    logic frameSelN;
    logic sdi;
    logic loadOutputsN;
    logic packetCheck;
    modport host (output sclk, output frameSelN, output sdi,
                  output loadOutputsN, output packetCheck);
    modport dev (input sclk, input frameSelN, input sdi,
                 input loadOutputsN, input packetCheck);
endinterface

/* File: hdl/dac_host.sv */
/*
 * Host end: waits out device calibration, then shifts frames out with a
 * divided link clock and drives the load line for both update modes.
 * Assumes user inputs are synchronous to clk.
 */
`timescale 1ns/100ps
module dac_host (
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    dac_link_if.host                           link,
    input  wire logic                          txValid,
    input  wire logic [dac_pkg::WORD_BITS-1:0] txWord,
    input  wire logic                          simMode,
    input  wire logic                          updateAll,
    input  wire logic                          pecEnable,
    output logic                               txReady
);
    import dac_pkg::*;

    typedef enum logic [2:0] {H_CAL, H_IDLE, H_SHIFT, H_GAP, H_LOAD} hstate_t;

    hstate_t             state_q;
    logic [HCNT_W-1:0]   cnt_q;
    logic [1:0]          ph_q;
    logic [CNT_W-1:0]    bits_q;
    logic [PEC_BITS-1:0] frame_q;
    logic                sclk_q;
    logic                fsN_q;
    logic                sdi_q;
    logic                ldN_q;
    logic                pec_q;

    assign link.sclk = sclk_q;
    assign link.frameSelN = fsN_q;
    assign link.sdi = sdi_q;
    assign link.loadOutputsN = ldN_q;
    assign link.packetCheck = pec_q;

    // Link clock is clk divided by four: data changes with the rising edge
    // and is sampled two clk cycles later on the falling edge.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= H_CAL;
            cnt_q   <= HCNT_W'(CAL_CYCLES);
            ph_q    <= '0;
            bits_q  <= '0;
            frame_q <= '0;
            sclk_q  <= 1'h1;
            fsN_q   <= 1'h1;
            sdi_q   <= 1'h0;
            ldN_q   <= 1'h1;
            pec_q   <= 1'h0;
            txReady <= 1'h0;
        end else begin
            case (state_q)
                H_CAL: begin
                    // The load line follows the mode only while frame select is
                    // high, so a mode change never lands inside a frame.
                    ldN_q <= simMode;
                    cnt_q <= cnt_q - HCNT_W'(1);
                    if (cnt_q == '0) begin
                        state_q <= H_IDLE;
                        txReady <= 1'h1;
                    end
                end
                H_IDLE: begin
                    pec_q <= pecEnable;
                    if (txValid && txReady) begin
                        frame_q <= pecEnable ? {txWord, crc8(txWord)}
                                             : {txWord, CRC_INIT};
                        bits_q  <= pecEnable ? LEN_PEC : LEN_PLAIN;
                        pec_q   <= pecEnable;
                        sdi_q   <= txWord[WORD_BITS-1];
                        fsN_q   <= 1'h0;
                        ph_q    <= '0;
                        txReady <= 1'h0;
                        state_q <= H_SHIFT;
                    end else if (updateAll && simMode && txReady) begin
                        ldN_q   <= 1'h0;
                        cnt_q   <= HCNT_W'(LD_PULSE_CYCLES);
                        txReady <= 1'h0;
                        state_q <= H_LOAD;
                    end else begin
                        ldN_q <= simMode;
                    end
                end
                H_SHIFT: begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h1) begin
                        sclk_q <= 1'h0;
                    end else if (ph_q == 2'h3) begin
                        sclk_q <= 1'h1;
                        if (bits_q == CNT_W'(1)) begin
                            fsN_q   <= 1'h1;
                            cnt_q   <= HCNT_W'(GAP_CYCLES);
                            state_q <= H_GAP;
                        end else begin
                            sdi_q   <= frame_q[PEC_BITS-2];
                            frame_q <= {frame_q[PEC_BITS-2:0], 1'h0};
                            bits_q  <= bits_q - CNT_W'(1);
                        end
                    end
                end
                H_GAP: begin
                    ldN_q <= simMode;
                    cnt_q <= cnt_q - HCNT_W'(1);
                    if (cnt_q == '0) begin
                        txReady <= 1'h1;
                        state_q <= H_IDLE;
                    end
                end
                H_LOAD: begin
                    cnt_q <= cnt_q - HCNT_W'(1);
                    if (cnt_q == '0) begin
                        ldN_q   <= 1'h1;
                        txReady <= 1'h1;
                        state_q <= H_IDLE;
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: verif/dac_link_monitor.sv */
/*
 * Concurrent checks on the serial link between the host and device ends.
 * Assumes the bench instantiates it beside the link, on the core clock.
 */
`timescale 1ns/100ps
module dac_link_monitor (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic frameSelN,
    input wire logic sdi,
    input wire logic loadOutputsN,
    input wire logic packetCheck
);
    logic [5:0] bitCnt_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // The host moves the link clock only on core edges, so core sampling sees every edge.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bitCnt_q <= 6'h00;
        end else if (frameSelN) begin
            bitCnt_q <= 6'h00;
        end else if ($fell(sclk)) begin
            bitCnt_q <= bitCnt_q + 6'h01;
        end
    end

    sequence sStart;
        $fell(frameSelN);
    endsequence
    sequence sEnd;
        $rose(frameSelN);
    endsequence
    sequence sLowPhase;
        !sclk ##1 !sclk ##1 sclk;
    endsequence

    AST_BIT_COUNT: assert property (sEnd |-> bitCnt_q == (packetCheck ? 6'h20 : 6'h18))
        else $error("Frame bit count differs from the selected length.");
    AST_FRAME_SPAN: assert property (sStart |-> ##[96:130] sEnd)
        else $error("Frame did not end in the expected span.");
    AST_CLOCK_STARTS: assert property (sStart |-> ##[1:4] $fell(sclk))
        else $error("No link clock edge after frame start.");
    AST_SCLK_SHAPE: assert property ($fell(sclk) |-> sLowPhase)
        else $error("Link clock low phase has the wrong length.");
    AST_SDI_AT_FALL: assert property ($fell(sclk) |-> $stable(sdi))
        else $error("Serial data moved at the sampling edge.");
    AST_SCLK_IDLE: assert property (frameSelN && $past(frameSelN) |-> sclk)
        else $error("Link clock not high between frames.");
    AST_PEC_HELD: assert property (!frameSelN && !$past(frameSelN) |-> $stable(packetCheck))
        else $error("Packet check changed inside a frame.");
    AST_LOAD_IDLE: assert property ($changed(loadOutputsN) |-> frameSelN && $past(frameSelN))
        else $error("Load line moved while a frame was open.");
    AST_LOAD_PULSE: assert property ($fell(loadOutputsN) |-> !loadOutputsN [*5])
        else $error("Load pulse too short.");
    AST_FRAME_GAP: assert property (sEnd |-> frameSelN [*5])
        else $error("Frame select gap too short.");
endmodule

/* File: verif/tb_quad_dac_serial_load_update.sv */
/*
 * Bench: host and device joined by one link, plus a second device fed by a
 * bench driver that sends malformed frames. Assumes dac_pkg is compiled first.
 */
`timescale 1ns/100ps
module tb_quad_dac_serial_load_update;
    import dac_pkg::*;
    logic                      clk;
    logic                      arst_n;
    logic                      txValid;
    logic                      simMode;
    logic                      updateAll;
    logic                      pecEnable;
    logic                      txReady;
    logic                      frameErr;
    logic                      frameErrB;
    logic [WORD_BITS-1:0]      txWord;
    logic [NCH-1:0]            chanTri;
    logic [NCH-1:0]            chanTriB;
    logic [NCH-1:0][CUR_W-1:0] cur;
    logic [NCH-1:0][CUR_W-1:0] curB;
    logic [NCH-1:0][SEG_W-1:0] seg;
    logic [NCH-1:0][SEG_W-1:0] segB;
    logic [NCH-1:0][LAD_W-1:0] lad;
    logic [NCH-1:0][LAD_W-1:0] ladB;
    logic [31:0]               capW;
    int                        capN = 0;
    int                        errA = 0;
    int                        errB = 0;
    int                        num_errors = 0;
    int                        n_compared = 0;

    dac_link_if link();
    dac_link_if linkB();

    dac_host dac_host_inst (.clk(clk), .arst_n(arst_n), .link(link.host), .txValid(txValid),
        .txWord(txWord), .simMode(simMode), .updateAll(updateAll), .pecEnable(pecEnable),
        .txReady(txReady));
    dac_device dac_device_inst (.clk(clk), .arst_n(arst_n), .link(link.dev),
        .channelCurrentOutput(cur), .chanTristate(chanTri), .segmentSwitches(seg),
        .ladderSwitches(lad), .frameErr(frameErr));
    dac_device dac_device_inst_b (.clk(clk), .arst_n(arst_n), .link(linkB.dev),
        .channelCurrentOutput(curB), .chanTristate(chanTriB), .segmentSwitches(segB),
        .ladderSwitches(ladB), .frameErr(frameErrB));
    dac_link_monitor dac_link_monitor_inst (.clk(clk), .arst_n(arst_n), .sclk(link.sclk),
        .frameSelN(link.frameSelN), .sdi(link.sdi), .loadOutputsN(link.loadOutputsN),
        .packetCheck(link.packetCheck));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Bits are captured off the wire itself, so word order is judged independently of the device.
    always @(negedge link.sclk) begin
        if (link.frameSelN === 1'b0) begin
            capW = {capW[30:0], link.sdi};
            capN++;
        end
    end

    always @(posedge clk) begin
        if (frameErr === 1'b1) errA++;
        if (frameErrB === 1'b1) errB++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("Mismatches %0d, comparisons %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (txReady !== 1'b1 && n < 5000) begin
            @(posedge clk);
            #2;
            n++;
        end
        if (n >= 5000) num_errors++;
    endtask

    task automatic send(input logic [1:0] cmd, input logic [1:0] ch, input logic [15:0] d,
                        input logic packet_check);
        logic [23:0] w;
        w = {cmd, ch, 4'h0, d};
        wait_ready();
        capN = 0;
        txWord = w;
        pecEnable = packet_check;
        txValid = 1'b1;
        @(posedge clk);
        #2;
        txValid = 1'b0;
        repeat (2) @(posedge clk);
        #2;
        wait_ready();
        chk(packet_check ? capW[31:8] : capW[23:0], {8'h00, w});
        chk(capN, packet_check ? 32'h20 : 32'h18);
        chk({link.sclk, link.frameSelN}, 32'h3);
    endtask

    task automatic upd();
        wait_ready();
        updateAll = 1'b1;
        @(posedge clk);
        #2;
        updateAll = 1'b0;
        repeat (2) @(posedge clk);
        #2;
        wait_ready();
    endtask

    task automatic chkCh(input logic b, input int ch, input logic [31:0] c,
                         input logic [14:0] s, input logic [11:0] l);
        chk(b ? curB[ch] : cur[ch], c);
        chk(b ? chanTriB[ch] : chanTri[ch], 32'h0);
        chk(b ? segB[ch] : seg[ch], {17'h0, s});
        chk(b ? ladB[ch] : lad[ch], {20'h0, l});
    endtask

    // The link clock made here runs only inside frames, at a 32 ns period.
    task automatic drvB(input logic [31:0] w, input int n, input logic packet_check);
        linkB.packetCheck = packet_check;
        #40;
        linkB.frameSelN = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            linkB.sdi = w[i];
            #16;
            linkB.sclk = 1'b0;
            #16;
            linkB.sclk = 1'b1;
        end
        #16;
        linkB.frameSelN = 1'b1;
        linkB.sdi = ~linkB.sdi;
        repeat (10) @(posedge clk);
        #2;
    endtask

    initial begin
        #800000;
        num_errors++;
        complete_run();
    end

    initial begin
        arst_n = 1'b0;
        txValid = 1'b0;
        txWord = 24'h000000;
        simMode = 1'b0;
        updateAll = 1'b0;
        pecEnable = 1'b0;
        linkB.sclk = 1'b1;
        linkB.frameSelN = 1'b1;
        linkB.sdi = 1'b0;
        linkB.loadOutputsN = 1'b0;
        linkB.packetCheck = 1'b0;
        repeat (20) @(posedge clk);
        #2;
        arst_n = 1'b1;
        chk(chanTri, 32'hF);
        chk(cur[0], 32'h0);
        repeat (CAL_CYCLES) @(posedge clk);
        #2;
        chk(txReady, 32'h0);
        send(CMD_RANGE, 2'h0, {14'h0, RANGE_0_20}, 1'b0);
        send(CMD_DATA, 2'h0, 16'h8000, 1'b0);
        chkCh(1'b0, 0, 32'hA0000, 15'h00FF, 12'h000);
        send(CMD_RANGE, 2'h1, {14'h0, RANGE_4_20}, 1'b0);
        send(CMD_DATA, 2'h1, 16'hFFFF, 1'b0);
        chkCh(1'b0, 1, 32'h13FFF0, 15'h7FFF, 12'hFFF);
        send(CMD_RANGE, 2'h2, {14'h0, RANGE_0_24}, 1'b1);
        send(CMD_DATA, 2'h2, 16'h1234, 1'b1);
        chkCh(1'b0, 2, 32'h1B4E0, 15'h0001, 12'h234);
        send(CMD_RANGE, 2'h3, {14'h0, RANGE_BAD}, 1'b0);
        send(CMD_DATA, 2'h3, 16'h0100, 1'b0);
        send(2'h2, 2'h3, 16'hFFFF, 1'b0);
        chkCh(1'b0, 3, 32'h1400, 15'h0000, 12'h100);
        simMode = 1'b1;
        repeat (12) @(posedge clk);
        #2;
        send(CMD_DATA, 2'h0, 16'h1000, 1'b0);
        chk(cur[0], 32'hA0000);
        send(CMD_DATA, 2'h0, 16'h2000, 1'b0);
        send(CMD_DATA, 2'h3, 16'h0200, 1'b0);
        upd();
        chkCh(1'b0, 0, 32'h14000, 15'h0001, 12'h000);
        chkCh(1'b0, 3, 32'h2800, 15'h0000, 12'h200);
        chk(cur[1], 32'h13FFF0);
        upd();
        chk(cur[0], 32'h14000);
        drvB({8'h00, CMD_DATA, 2'h2, 4'h0, 16'h5A5A}, 24, 1'b0);
        chkCh(1'b1, 2, 32'h70F08, 15'h001F, 12'hA5A);
        chk(errB, 32'h0);
        drvB({8'h00, CMD_DATA, 2'h2, 4'h0, 16'h1111}, 23, 1'b0);
        chk(errB, 32'h1);
        drvB({8'h00, CMD_DATA, 2'h2, 4'h0, 16'h2222}, 24, 1'b1);
        chk(errB, 32'h2);
        drvB({CMD_DATA, 2'h2, 4'h0, 16'h3333,
              crc8({CMD_DATA, 2'h2, 4'h0, 16'h3333}) ^ 8'hFF}, 32, 1'b1);
        chk(errB, 32'h3);
        chk(curB[2], 32'h70F08);
        chk(errA, 32'h0);
        complete_run();
    end
endmodule
